// ===== rtl/cs_pkg.sv
package cs_pkg;
    // slot array geometry
    localparam int unsigned SLOTS = 16;
    localparam int unsigned RES_W = 12;
    localparam int unsigned CNT_W = 8;

    // register byte offsets within the 256-byte window
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_IE = 8'h08;
    localparam logic [7:0] OFF_VECTOR = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [1:0] AREA_SLOTCTL = 2'h1;
    localparam logic [1:0] AREA_RESULT = 2'h2;

    // control word fields
    localparam int unsigned CTL_MODE_LSB = 0;
    localparam int unsigned CTL_ENABLE = 2;
    localparam int unsigned CTL_SW_START = 3;
    localparam int unsigned CTL_MULTI = 4;
    localparam int unsigned CTL_TRIG_SRC = 5;
    localparam int unsigned CTL_GLOBAL_IE = 6;
    localparam int unsigned CTL_OV_IE = 7;
    localparam int unsigned CTL_TOV_IE = 8;
    localparam int unsigned CTL_REF_ON = 9;
    localparam int unsigned CTL_START_LSB = 12;

    // slot control fields
    localparam int unsigned SC_CHAN_LSB = 0;
    localparam int unsigned SC_SEQ_END = 7;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IE_RST = 16'h0000;
    localparam logic [7:0] SLOTCTL_RST = 8'h00;

    // conversion_mode_sel codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SEQ_ONCE = 2'h1;
    localparam logic [1:0] MODE_REPEAT_SINGLE = 2'h2;
    localparam logic [1:0] MODE_REPEAT_SEQ = 2'h3;

    localparam logic [3:0] TEMP_CHANNEL = 4'hA;

    // irq_vector_word values
    localparam logic [5:0] VEC_NONE = 6'h00;
    localparam logic [5:0] VEC_OV = 6'h02;
    localparam logic [5:0] VEC_TOV = 6'h04;
    localparam logic [5:0] VEC_FLAG_BASE = 6'h06;

    // sampling window of the sample timer
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SAMPLE_TIME_NS = 80;
    localparam int unsigned SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CS_IDLE, CS_SAMPLE, CS_CONVERT, CS_SEQ_WAIT} cs_phase_e;

    typedef struct packed {
        logic start;
        logic abort;
        logic [3:0] channel;
    } cs_conv_req_s;

    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } cs_conv_res_s;

    // highest enabled pending source wins; overwrite first, then overrun, then slot 0 upward
    function automatic logic [5:0] cs_vector(input logic ov, input logic tov, input logic [SLOTS-1:0] pend);
        logic [5:0] v;
        v = VEC_NONE;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (pend[i]) v = VEC_FLAG_BASE + 6'(2 * i);
        end
        if (tov) v = VEC_TOV;
        if (ov) v = VEC_OV;
        return v;
    endfunction : cs_vector
endpackage : cs_pkg

// ===== rtl/cs_seq.sv
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - mode select: 00 single once, 01 sequence once, 10 single repeat, 11 sequence repeat
// - software start retriggers single-shot modes; other triggers need enable toggled
// - sequence-once fills consecutive slots from start slot, halts after end-marked slot
// - repeat-single converts continuously into the start slot, overwriting it
// - repeat-sequence ends each pass at end-marked slot; next trigger restarts
// - multi-sample: first trigger edge starts, later conversions start automatically
// - multi-sample ignores edges until a sequence-once run is done or enable toggled
// - clearing enable in single-once mode aborts at once; software waits busy first
// - clearing enable in repeat-single finishes current conversion then stops
// - clearing enable in sequence modes stops only when the sequence ends
// - mode zero with enable cleared aborts any activity immediately
// - without end-marked slot, software selects single mode before clearing enable
// - channel 1010 powers the reference, leaving pin and reference selection alone
// - eighteen irq sources: sixteen result flags, overwrite, timing overrun
// - result write sets slot flag; request needs slot enable and global enable
// - overwrite on unread slot rewrite; overrun on trigger during conversion
// - dma pulse per conversion in single modes, per sequence in sequence modes
// - vector word reports highest enabled pending source; disabled ones ignored
// - vector access clears overwrite or overrun if highest; flags untouched
// - result read clears its flag; software may also clear flags
// - remaining enabled pending sources keep requesting after one is serviced
// - vector: 0 none, 2 overwrite, 4 overrun, 6 upward in twos for slots
// - slot pointer advances per conversion in sequence modes, wraps 15 to 0 without end mark
module cs_seq #(
    parameter int unsigned SAMPLE_CYCLES = cs_pkg::SAMPLE_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sample_trigger_input,
    input wire cs_pkg::cs_conv_res_s conv_res,
    output cs_pkg::cs_conv_req_s conv_req,
    output logic busy,
    output logic dma_trigger,
    output logic irq_req,
    output logic ref_power_on
);
    import cs_pkg::*;

    typedef struct packed {
        cs_phase_e phase;
        logic [15:0] ctrl;
        logic [SLOTS-1:0] ie;
        logic [SLOTS-1:0] flags;
        logic [SLOTS-1:0] unread;
        logic ov;
        logic tov;
        logic [SLOTS-1:0][7:0] slotctl;
        logic [SLOTS-1:0][RES_W-1:0] result;
        logic [3:0] ptr;
        logic [CNT_W-1:0] samp_cnt;
        logic armed;
        logic multi_lock;
        logic en_prev;
        logic dma;
        logic conv_start;
        logic conv_abort;
        logic dph_sel;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
    } cs_state_s;

    cs_state_s s_ff;
    cs_state_s nxt_s;

    logic trig_level;
    logic trig_rise;
    logic take;
    logic wr;
    logic [15:0] ctrl_now;
    logic [1:0] mode;
    logic en;
    logic en_rise;
    logic sw_trig;
    logic trig;
    logic multi_on;
    logic abort_now;
    logic conv_wr;
    logic seq_end_now;
    logic vec_access;
    logic [5:0] vec_now;
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;
    logic [31:0] rd_mux;

    // trigger pin crosses into hclk through three stages
    cs_sync3 u_trig_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .din(sample_trigger_input),
        .level(trig_level),
        .rise(trig_rise)
    );

    // bus phases: address taken when selected and ready, write data lands one cycle later
    assign take = hsel & htrans[1] & hready;
    assign wr = s_ff.dph_sel & s_ff.dph_wr;
    assign rd_idx = haddr[5:2];
    assign wr_idx = s_ff.dph_addr[5:2];
    assign vec_access = take && (haddr[7:0] == OFF_VECTOR);

    // a control write takes effect for the sequencer in its own data phase
    always_comb begin
        ctrl_now = s_ff.ctrl;
        if (wr && s_ff.dph_addr == OFF_CTRL) begin
            ctrl_now = hwdata[15:0];
            ctrl_now[CTL_SW_START] = 1'b0; // start bit is a strobe, never stored
        end
    end

    assign mode = ctrl_now[CTL_MODE_LSB +: 2];
    assign en = ctrl_now[CTL_ENABLE];
    assign en_rise = en & ~s_ff.en_prev;
    assign sw_trig = wr && s_ff.dph_addr == OFF_CTRL && hwdata[CTL_SW_START];
    assign trig = ctrl_now[CTL_TRIG_SRC] ? trig_rise : sw_trig;
    assign multi_on = ctrl_now[CTL_MULTI] && mode != MODE_SINGLE;
    assign abort_now = !en && mode == MODE_SINGLE && s_ff.phase != CS_IDLE;
    assign conv_wr = s_ff.phase == CS_CONVERT && conv_res.done && !abort_now;
    assign seq_end_now = s_ff.slotctl[s_ff.ptr][SC_SEQ_END];

    // disabled sources never reach the vector
    assign vec_now = cs_vector(s_ff.ov & s_ff.ctrl[CTL_OV_IE], s_ff.tov & s_ff.ctrl[CTL_TOV_IE],
                               s_ff.flags & s_ff.ie);

    // read mux sampled at the address phase so hrdata comes from a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:6] == AREA_SLOTCTL) begin
            rd_mux = {24'h00_0000, s_ff.slotctl[rd_idx]};
        end else if (haddr[7:6] == AREA_RESULT) begin
            rd_mux = {20'h0_0000, s_ff.result[rd_idx]};
        end else begin
            unique case (haddr[7:0])
                OFF_CTRL: rd_mux = {16'h0000, s_ff.ctrl};
                OFF_FLAGS: rd_mux = {16'h0000, s_ff.flags};
                OFF_IE: rd_mux = {16'h0000, s_ff.ie};
                OFF_VECTOR: rd_mux = {26'h000_0000, vec_now};
                OFF_STATUS: rd_mux = {29'h0000_0000, trig_level, ref_power_on, busy};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // next state: clears first, hardware sets after, so a set in the same cycle wins
    always_comb begin
        nxt_s = s_ff;
        nxt_s.dma = 1'b0;
        nxt_s.conv_start = 1'b0;
        nxt_s.conv_abort = 1'b0;
        nxt_s.dph_sel = take;
        nxt_s.dph_wr = hwrite;
        nxt_s.dph_addr = haddr[7:0];
        if (take && !hwrite) begin
            nxt_s.rdata = rd_mux;
        end
        nxt_s.ctrl = ctrl_now;
        nxt_s.en_prev = en;
        // software writes
        if (wr && s_ff.dph_addr == OFF_IE) begin
            nxt_s.ie = hwdata[15:0];
        end
        if (wr && s_ff.dph_addr == OFF_FLAGS) begin
            nxt_s.flags = s_ff.flags & ~hwdata[15:0];
        end
        if (wr && s_ff.dph_addr[7:6] == AREA_SLOTCTL) begin
            nxt_s.slotctl[wr_idx] = hwdata[7:0];
        end
        // reading a result slot retires its flag
        if (take && !hwrite && haddr[7:6] == AREA_RESULT) begin
            nxt_s.flags[rd_idx] = 1'b0;
            nxt_s.unread[rd_idx] = 1'b0;
        end
        // vector access retires only overwrite or overrun, and only the one that stands highest
        if (vec_access) begin
            if (vec_now == VEC_OV) begin
                nxt_s.ov = 1'b0;
            end else if (vec_now == VEC_TOV) begin
                nxt_s.tov = 1'b0;
            end
        end
        // enable toggled: re-arm hardware triggers and release the multi-sample lock
        if (en_rise) begin
            nxt_s.armed = 1'b1;
            nxt_s.multi_lock = 1'b0;
        end
        unique case (s_ff.phase)
            CS_IDLE: begin
                if (trig && en && (!ctrl_now[CTL_TRIG_SRC] || s_ff.armed) && !s_ff.multi_lock) begin
                    nxt_s.phase = CS_SAMPLE;
                    nxt_s.ptr = ctrl_now[CTL_START_LSB +: 4];
                    nxt_s.samp_cnt = '0;
                    nxt_s.multi_lock = multi_on;
                end
            end
            CS_SEQ_WAIT: begin
                // mid-sequence without multi-sample: each conversion waits for its trigger
                if (trig && !s_ff.multi_lock) begin
                    nxt_s.phase = CS_SAMPLE;
                    nxt_s.samp_cnt = '0;
                end
            end
            CS_SAMPLE: begin
                if (trig && !s_ff.multi_lock) begin
                    nxt_s.tov = 1'b1;
                end
                if (s_ff.samp_cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
                    nxt_s.phase = CS_CONVERT;
                    nxt_s.conv_start = 1'b1;
                end else begin
                    nxt_s.samp_cnt = s_ff.samp_cnt + 1'b1;
                end
            end
            CS_CONVERT: begin
                if (trig && !s_ff.multi_lock) begin
                    nxt_s.tov = 1'b1;
                end
                if (conv_wr) begin
                    if (s_ff.unread[s_ff.ptr]) begin
                        nxt_s.ov = 1'b1;
                    end
                    nxt_s.result[s_ff.ptr] = conv_res.data;
                    nxt_s.flags[s_ff.ptr] = 1'b1;
                    nxt_s.unread[s_ff.ptr] = 1'b1;
                    nxt_s.samp_cnt = '0;
                    if (!mode[0]) begin
                        // single-channel modes: one dma pulse per conversion
                        nxt_s.dma = 1'b1;
                        if (mode == MODE_REPEAT_SINGLE && en && multi_on) begin
                            nxt_s.phase = CS_SAMPLE;
                        end else begin
                            nxt_s.phase = CS_IDLE;
                        end
                        if (mode == MODE_SINGLE && ctrl_now[CTL_TRIG_SRC]) begin
                            nxt_s.armed = 1'b0;
                        end
                    end else if (seq_end_now) begin
                        // sequence complete; enable is only looked at here
                        nxt_s.dma = 1'b1;
                        nxt_s.ptr = ctrl_now[CTL_START_LSB +: 4];
                        if (mode == MODE_REPEAT_SEQ && en && multi_on) begin
                            nxt_s.phase = CS_SAMPLE;
                        end else begin
                            nxt_s.phase = CS_IDLE;
                        end
                        if (mode == MODE_SEQ_ONCE) begin
                            nxt_s.multi_lock = 1'b0;
                            nxt_s.armed = !ctrl_now[CTL_TRIG_SRC];
                        end
                    end else begin
                        // no end mark: pointer wraps from 15 to 0 and enable alone cannot stop it
                        nxt_s.ptr = s_ff.ptr + 4'h1;
                        nxt_s.phase = multi_on ? CS_SAMPLE : CS_SEQ_WAIT;
                    end
                end
            end
        endcase
        // immediate stop; the result in flight is dropped, the core is told to quit
        if (abort_now) begin
            nxt_s.phase = CS_IDLE;
            nxt_s.conv_abort = 1'b1;
            nxt_s.conv_start = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.phase <= CS_IDLE;
            s_ff.ctrl <= CTRL_RST;
            s_ff.ie <= IE_RST;
            s_ff.slotctl <= {SLOTS{SLOTCTL_RST}};
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // outputs; slave is zero-wait and always answers okay
    assign hrdata = s_ff.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign busy = s_ff.phase != CS_IDLE;
    assign dma_trigger = s_ff.dma;
    assign irq_req = s_ff.ctrl[CTL_GLOBAL_IE] && vec_now != VEC_NONE;
    assign conv_req.start = s_ff.conv_start;
    assign conv_req.abort = s_ff.conv_abort;
    assign conv_req.channel = s_ff.slotctl[s_ff.ptr][SC_CHAN_LSB +: 4];
    // temperature channel powers the reference only; selection and pin are left alone
    assign ref_power_on = s_ff.ctrl[CTL_REF_ON] || (busy && conv_req.channel == TEMP_CHANNEL);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !ce);

    a_flag_on_write: assert property (conv_wr |=> s_ff.flags[$past(s_ff.ptr)])
        else $error("result flag not set after slot write");
    a_irq_gating: assert property (irq_req |-> s_ff.ctrl[CTL_GLOBAL_IE] && (s_ff.flags & s_ff.ie) != '0 ||
                                   s_ff.ov && s_ff.ctrl[CTL_OV_IE] || s_ff.tov && s_ff.ctrl[CTL_TOV_IE])
        else $error("irq without enabled pending source");
    a_ov_raise: assert property (conv_wr && s_ff.unread[s_ff.ptr] |=> s_ff.ov)
        else $error("overwrite not flagged");
    a_tov_raise: assert property (trig && !s_ff.multi_lock && (s_ff.phase == CS_SAMPLE || s_ff.phase == CS_CONVERT)
                                  |=> s_ff.tov)
        else $error("overrun not flagged");
    a_dma_single: assert property (conv_wr && !mode[0] |=> dma_trigger ##1 !dma_trigger)
        else $error("dma pulse missing in single mode");
    a_ptr_step: assert property (conv_wr && mode[0] && !seq_end_now |=> s_ff.ptr == $past(s_ff.ptr) + 4'h1)
        else $error("slot pointer did not advance");
    a_abort_now: assert property (abort_now |=> s_ff.phase == CS_IDLE && conv_req.abort && !busy)
        else $error("single-once abort not immediate");
    a_vec_ov_clear: assert property (vec_access && vec_now == VEC_OV && !(conv_wr && s_ff.unread[s_ff.ptr])
                                     |=> !s_ff.ov)
        else $error("vector access kept overwrite");
    a_seq_once_end: assert property (conv_wr && mode == MODE_SEQ_ONCE && seq_end_now |=> !busy)
        else $error("sequence did not halt at end mark");

    c_repeat_pass: cover property (conv_wr && mode == MODE_REPEAT_SEQ && seq_end_now);
    c_vec_tov: cover property (vec_access && vec_now == VEC_TOV);
    c_multi_auto: cover property (s_ff.phase == CS_CONVERT && conv_wr ##1 s_ff.phase == CS_SAMPLE);
endmodule : cs_seq
`default_nettype wire

// ===== rtl/cs_sync3.sv
`timescale 1ns/1ns
`default_nettype none
module cs_sync3 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
        logic rise;
    } cs_sync_s;

    cs_sync_s s_ff;
    cs_sync_s nxt_s;

    // stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sh = {s_ff.sh[1:0], din};
        nxt_s.rise = 1'b0;
        if (s_ff.sh[2] == s_ff.sh[1]) begin
            nxt_s.lvl = s_ff.sh[2];
            nxt_s.rise = s_ff.sh[2] & ~s_ff.lvl;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign level = s_ff.lvl;
    assign rise = s_ff.rise;
endmodule : cs_sync3
`default_nettype wire

// ===== verification/test_conversion_sequencer_irq.sv
`timescale 1ns/1ns
`default_nettype none
module test_conversion_sequencer_irq;
    import cs_pkg::*;
    logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, sample_trigger_input;
    logic busy, dma_trigger, irq_req, ref_power_on, ref_seen;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    cs_conv_res_s conv_res;
    cs_conv_req_s conv_req;
    logic [31:0] seed = 32'h50DA;
    int n_errors = 0, checks = 0, n_dma = 0, lat = 0, q0 = 0;
    logic [11:0] q[$];

    cs_seq #(.SAMPLE_CYCLES(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sample_trigger_input(sample_trigger_input), .conv_res(conv_res),
        .conv_req(conv_req), .busy(busy), .dma_trigger(dma_trigger), .irq_req(irq_req),
        .ref_power_on(ref_power_on));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // analog core stand-in: random latency and random results, each logged in the model queue
    always @(posedge hclk) begin
        conv_res.done <= 1'b0;
        if (conv_req.start === 1'b1) begin
            seed = xs(seed);
            lat <= 3 + int'(seed[2:0]);
        end else if (conv_req.abort === 1'b1) begin
            // a result that lands in the abort cycle is dropped by the sequencer
            if (conv_res.done === 1'b1) void'(q.pop_back());
            lat <= 0;
        end else if (lat == 1) begin
            conv_res.done <= 1'b1;
            conv_res.data <= seed[23:12];
            q.push_back(seed[23:12]);
            lat <= 0;
        end else if (lat > 1) begin
            lat <= lat - 1;
        end
        if (dma_trigger === 1'b1) n_dma++;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one single ahb transfer; waits on hready in both phases, never on a fixed count
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            n_errors++;
            report_and_stop();
        end
    endtask : ahb

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(what, rd, e);
    endtask : rd_chk

    // busy may take a few cycles to rise, so give it time before polling it low
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge hclk);
        while (busy !== 1'b0 && n < 500) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 500) begin
            n_errors++;
            report_and_stop();
        end
        repeat (2) @(posedge hclk);
    endtask : wait_idle

    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sample_trigger_input = 1'b0;
        conv_res = '0;
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("ctrl reset", OFF_CTRL, 32'h0);
        rd_chk("vector reset", OFF_VECTOR, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        check("irq reset", {31'h0, irq_req}, 32'h0);
        $display("test reset done");
        // software start into slot 3, twice without reading so the second overwrites
        ahb(1'b1, 8'h4C, 32'h5);
        ahb(1'b1, OFF_IE, 32'h8);
        ahb(1'b1, OFF_CTRL, 32'h30CC);
        wait_idle();
        check("dma single", n_dma, 32'd1);
        rd_chk("flags slot3", OFF_FLAGS, 32'h8);
        rd_chk("vector slot3", OFF_VECTOR, 32'hC);
        check("irq slot3", {31'h0, irq_req}, 32'h1);
        ahb(1'b1, OFF_CTRL, 32'h30CC);
        wait_idle();
        rd_chk("vector ov", OFF_VECTOR, 32'h2);
        rd_chk("vector after ov", OFF_VECTOR, 32'hC);
        check("irq still", {31'h0, irq_req}, 32'h1);
        rd_chk("flags kept", OFF_FLAGS, 32'h8);
        rd_chk("result3", 8'h8C, {20'h0, q[1]});
        rd_chk("flags read clear", OFF_FLAGS, 32'h0);
        check("irq none", {31'h0, irq_req}, 32'h0);
        $display("test single done");
        // sequence once over slots 0 to 2, end mark on slot 2
        ahb(1'b1, 8'h40, 32'h1);
        ahb(1'b1, 8'h44, 32'h2);
        ahb(1'b1, 8'h48, 32'h83);
        ahb(1'b1, OFF_CTRL, 32'h005D);
        wait_idle();
        check("dma sequence", n_dma, 32'd3);
        rd_chk("flags seq", OFF_FLAGS, 32'h7);
        rd_chk("vector disabled", OFF_VECTOR, 32'h0);
        ahb(1'b1, OFF_IE, 32'h4);
        rd_chk("vector slot2", OFF_VECTOR, 32'hA);
        ahb(1'b1, OFF_FLAGS, 32'h4);
        rd_chk("flags sw clear", OFF_FLAGS, 32'h3);
        for (int i = 0; i < 3; i++) begin
            rd_chk("seq result", 8'(128 + 4 * i), {20'h0, q[2 + i]});
        end
        $display("test sequence done");
        // repeat single into slot 6, then mode zero with enable cleared
        ahb(1'b1, OFF_CTRL, 32'h601E);
        repeat (80) @(posedge hclk);
        check("repeat runs", {31'h0, q.size() > 6}, 32'h1);
        ahb(1'b1, OFF_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        check("abort busy", {31'h0, busy}, 32'h0);
        rd_chk("result6", 8'h98, {20'h0, q[$]});
        $display("test repeat done");
        // pin trigger on the temperature channel in slot 5
        ahb(1'b1, 8'h54, 32'hA);
        ahb(1'b1, OFF_CTRL, 32'h5024);
        q0 = q.size();
        ref_seen = 1'b0;
        sample_trigger_input <= 1'b1;
        repeat (30) begin
            @(posedge hclk);
            if (busy === 1'b1 && ref_power_on === 1'b1) ref_seen = 1'b1;
        end
        sample_trigger_input <= 1'b0;
        wait_idle();
        check("ref on temp", {31'h0, ref_seen}, 32'h1);
        check("ref off idle", {31'h0, ref_power_on}, 32'h0);
        check("pin conv", q.size(), q0 + 1);
        sample_trigger_input <= 1'b1;
        repeat (10) @(posedge hclk);
        sample_trigger_input <= 1'b0;
        repeat (40) @(posedge hclk);
        check("no rearm", q.size(), q0 + 1);
        ahb(1'b1, 8'h94, 32'hFFF);
        rd_chk("result5", 8'h94, {20'h0, q[q0]});
        $display("test pin done");
        report_and_stop();
    end
endmodule : test_conversion_sequencer_irq
`default_nettype wire
